// ===== verilog/adt_pkg.sv
package adt_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL_A = 8'h7A;
    localparam logic [7:0] IDX_CTRL_B = 8'h7B;
    localparam logic [7:0] IDX_INPUT_OFF = 8'h7E;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_A = ADDR_W'({IDX_CTRL_A, 2'h0});
    localparam logic [ADDR_W-1:0] ADDR_CTRL_B = ADDR_W'({IDX_CTRL_B, 2'h0});
    localparam logic [ADDR_W-1:0] ADDR_INPUT_OFF =
        ADDR_W'({IDX_INPUT_OFF, 2'h0});

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    // converter_control_a
    localparam int BIT_ENABLE = 7;
    localparam int BIT_START = 6;
    localparam int BIT_AUTO = 5;
    localparam int BIT_DONE = 4;
    localparam int BIT_DONE_IE = 3;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 3;
    // converter_control_b
    localparam int BIT_MUX_EN = 6;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 3;
    // digital_input_disable
    localparam int OFF_LSB = 0;
    localparam int NUM_DIG_PINS = 6;

    // values after reset
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] INPUT_OFF_RST = 8'h00;

    // trigger source codes
    localparam logic [SEL_W-1:0] SRC_FREE_RUN = 3'h0;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0] pstrb;
    } adt_apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } adt_apb_rsp_s;

    // event flags, one per trigger code 7 down to 1
    typedef struct packed {
        logic t1Capture;
        logic t1Overflow;
        logic t1CompareB;
        logic t0Overflow;
        logic t0CompareA;
        logic extInt0;
        logic comparator;
    } adt_trig_s;

    typedef struct packed {
        logic convOn;
        logic convStart;
        logic [DIV_W-1:0] clkDiv;
        logic doneIrqEn;
        logic doneFlag;
        logic compMuxEn;
    } adt_conv_s;

    // ------------------------------------------------------------------
    // module state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [NUM_DIG_PINS-1:0] stage1;
        logic [NUM_DIG_PINS-1:0] stage2;
    } adt_sync_s;

    typedef struct packed {
        logic convOn;
        logic busy;
        logic autoTrig;
        logic doneFlag;
        logic doneIe;
        logic [DIV_W-1:0] clkDiv;
        logic muxEn;
        logic [SEL_W-1:0] trigSel;
        logic [NUM_DIG_PINS-1:0] inputOff;
        logic trigPrev;
        logic startPulse;
        logic [NUM_DIG_PINS-1:0] pinValue;
        logic [DATA_W-1:0] rdData;
    } adt_state_s;

    // all register fields reset to zero
    localparam adt_state_s STATE_RST = '0;

endpackage : adt_pkg

// ===== verilog/adt_sync.sv
`timescale 1ns/100ps
module adt_sync
    import adt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // pins and synchronised copy
    input wire logic [NUM_DIG_PINS-1:0] pinRaw,
    output logic [NUM_DIG_PINS-1:0] pinSync
);

    adt_sync_s s_reg;
    adt_sync_s s_next;

    // ------------------------------------------------------------------
    // two stages; only stage2 leaves this module
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.stage1 = pinRaw;
        s_next.stage2 = s_reg.stage1;
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign pinSync = s_reg.stage2;

endmodule : adt_sync

// ===== verilog/adt_ctrl.sv
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
module adt_ctrl
    import adt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire adt_apb_req_s apbReq,
    output adt_apb_rsp_s apbRsp,
    // trigger event flags
    input wire adt_trig_s trig,
    // converter core
    input wire logic convDone,
    output adt_conv_s conv,
    // analog pins digital side
    input wire logic [NUM_DIG_PINS-1:0] pinRaw,
    output logic [NUM_DIG_PINS-1:0] inputBufferOff,
    output logic [NUM_DIG_PINS-1:0] pinValue
);

    adt_state_s s_reg;
    adt_state_s s_next;

    logic [NUM_DIG_PINS-1:0] pinSync;
    logic [7:0] srcVec;
    logic selFlag;
    logic trigEdge;
    logic selA;
    logic selB;
    logic selD;
    logic addrHit;
    logic access;
    logic wrA;
    logic wrB;
    logic wrD;
    logic rdSetup;
    logic finished;
    logic swStart;
    logic hwTrig;
    logic freeRun;
    logic launch;
    logic enNext;
    logic [7:0] rdByte;

    // ------------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------------
    adt_sync u_sync (
        .clk(clk),
        .resetn(resetn),
        .pinRaw(pinRaw),
        .pinSync(pinSync)
    );

    // ------------------------------------------------------------------
    // trigger source selection and edge detect
    // ------------------------------------------------------------------
    // code zero has no flag, so free running can never raise an edge
    assign srcVec = {trig, 1'b0};
    assign selFlag = srcVec[s_reg.trigSel];
    // the previous sample is of the muxed flag, so a source switch
    // from clear to set looks like a rising edge
    assign trigEdge = selFlag & ~s_reg.trigPrev;

    // ------------------------------------------------------------------
    // apb decode; zero wait states
    // ------------------------------------------------------------------
    assign selA = (apbReq.paddr == ADDR_CTRL_A);
    assign selB = (apbReq.paddr == ADDR_CTRL_B);
    assign selD = (apbReq.paddr == ADDR_INPUT_OFF);
    assign addrHit = selA | selB | selD;
    assign access = apbReq.psel & apbReq.penable;
    // narrow registers sit in lane 0; other lanes are ignored
    assign wrA = access & apbReq.pwrite & apbReq.pstrb[0] & selA;
    assign wrB = access & apbReq.pwrite & apbReq.pstrb[0] & selB;
    assign wrD = access & apbReq.pwrite & apbReq.pstrb[0] & selD;
    // read data is captured in setup so it is a flop in the access phase
    assign rdSetup = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;

    // read mux; reserved bits read as zero
    always_comb begin
        rdByte = 8'h00;
        if (selA) begin
            rdByte[BIT_ENABLE] = s_reg.convOn;
            rdByte[BIT_START] = s_reg.busy;
            rdByte[BIT_AUTO] = s_reg.autoTrig;
            rdByte[BIT_DONE] = s_reg.doneFlag;
            rdByte[BIT_DONE_IE] = s_reg.doneIe;
            rdByte[DIV_LSB +: DIV_W] = s_reg.clkDiv;
        end else if (selB) begin
            rdByte[BIT_MUX_EN] = s_reg.muxEn;
            rdByte[SEL_LSB +: SEL_W] = s_reg.trigSel;
        end else if (selD) begin
            rdByte[OFF_LSB +: NUM_DIG_PINS] = s_reg.inputOff;
        end
    end

    // ------------------------------------------------------------------
    // conversion start decisions
    // ------------------------------------------------------------------
    // a completion only counts for a conversion that is running
    assign finished = convDone & s_reg.busy;
    // start may be written together with enable
    assign swStart = wrA & apbReq.pwdata[BIT_START]
        & apbReq.pwdata[BIT_ENABLE];
    // the source field is only looked at with auto trigger on
    assign hwTrig = s_reg.autoTrig & trigEdge;
    assign freeRun = s_reg.autoTrig & finished
        & (s_reg.trigSel == SRC_FREE_RUN);
    // enable as it will stand after this edge; taken from the bus and not
    // from s_next, so the start path has no loop through the state copy
    assign enNext = wrA ? apbReq.pwdata[BIT_ENABLE] : s_reg.convOn;
    // starts while busy are dropped, except at the completing cycle
    assign launch = enNext
        & (swStart | ((hwTrig | freeRun) & s_reg.convOn))
        & (~s_reg.busy | finished);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        // control A writes
        if (wrA) begin
            s_next.convOn = apbReq.pwdata[BIT_ENABLE];
            s_next.autoTrig = apbReq.pwdata[BIT_AUTO];
            s_next.doneIe = apbReq.pwdata[BIT_DONE_IE];
            s_next.clkDiv = apbReq.pwdata[DIV_LSB +: DIV_W];
        end
        // control B writes; reserved bits are not stored
        if (wrB) begin
            s_next.muxEn = apbReq.pwdata[BIT_MUX_EN];
            s_next.trigSel = apbReq.pwdata[SEL_LSB +: SEL_W];
        end
        // input disable writes; bits 7:6 dropped
        if (wrD) begin
            s_next.inputOff = apbReq.pwdata[OFF_LSB +: NUM_DIG_PINS];
        end
        // done flag: write one clears, a completion in the same cycle wins
        s_next.doneFlag = (s_reg.doneFlag
            & ~(wrA & apbReq.pwdata[BIT_DONE])) | finished;
        // sample the muxed flag every clock
        s_next.trigPrev = selFlag;
        s_next.startPulse = launch;
        // busy follows start and completion; disable aborts
        if (launch) begin
            s_next.busy = 1'b1;
        end else if (finished) begin
            s_next.busy = 1'b0;
        end
        if (!s_next.convOn) begin
            s_next.busy = 1'b0;
        end
        // masked pins read zero from the cycle the bit is stored
        s_next.pinValue = pinSync & ~s_next.inputOff;
        if (rdSetup) begin
            s_next.rdData = {24'h000000, rdByte};
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign apbRsp = '{
        prdata: s_reg.rdData,
        pready: 1'b1,
        pslverr: access & ~addrHit
    };

    assign conv = '{
        convOn: s_reg.convOn,
        convStart: s_reg.startPulse,
        clkDiv: s_reg.clkDiv,
        doneIrqEn: s_reg.doneIe,
        doneFlag: s_reg.doneFlag,
        compMuxEn: s_reg.muxEn
    };

    // buffers off straight from the register bits
    assign inputBufferOff = s_reg.inputOff;
    assign pinValue = s_reg.pinValue;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_edge_start;
        (trigEdge && s_reg.autoTrig && s_reg.convOn && !s_reg.busy && !wrA)
            |=> conv.convStart && s_reg.busy;
    endproperty
    a_edge_start: assert property (p_edge_start)
        else $error("trigger edge did not start a conversion");

    property p_level_no_start;
        (selFlag && s_reg.trigPrev && !s_reg.busy && !wrA
            && s_reg.trigSel != SRC_FREE_RUN) |=> !conv.convStart;
    endproperty
    a_level_no_start: assert property (p_level_no_start)
        else $error("flag level started a conversion");

    property p_auto_off;
        (!s_reg.autoTrig && !wrA) |=> !conv.convStart;
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("start without auto trigger or software");

    property p_free_no_edge;
        (s_reg.trigSel == SRC_FREE_RUN) |-> !trigEdge;
    endproperty
    a_free_no_edge: assert property (p_free_no_edge)
        else $error("free running selection raised an edge");

    property p_switch_edge;
        (wrB && !selFlag && srcVec[apbReq.pwdata[SEL_LSB +: SEL_W]])
            ##1 $stable(trig) |-> trigEdge;
    endproperty
    a_switch_edge: assert property (p_switch_edge)
        else $error("source switch to set flag gave no edge");

    property p_done_sets;
        finished |=> conv.doneFlag && (!s_reg.busy || conv.convStart);
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("done flag not set after completion");

    property p_off_no_start;
        (!s_reg.convOn && !wrA) ##1 !wrA |-> !conv.convStart [*2];
    endproperty
    a_off_no_start: assert property (p_off_no_start)
        else $error("disabled converter started");

    property p_free_restart;
        (freeRun && s_reg.convOn && !wrA) |=> conv.convStart && s_reg.busy;
    endproperty
    a_free_restart: assert property (p_free_restart)
        else $error("free running did not restart");

    property p_pin_masked;
        (pinValue & inputBufferOff) == '0;
    endproperty
    a_pin_masked: assert property (p_pin_masked)
        else $error("disabled pin reads one");

    property p_resv_b;
        (rdSetup && selB) |=> (apbRsp.prdata[7] == 1'b0)
            && (apbRsp.prdata[5:3] == 3'h0);
    endproperty
    a_resv_b: assert property (p_resv_b)
        else $error("reserved control B bits read non zero");

    // further guards on bus writes and on state that must hold
    property p_sw_start;
        (swStart && !s_reg.busy) |=> conv.convStart && s_reg.busy;
    endproperty
    a_sw_start: assert property (p_sw_start)
        else $error("software start was not launched");

    property p_disable_abort;
        (wrA && !apbReq.pwdata[BIT_ENABLE]) |=> !conv.convOn && !s_reg.busy;
    endproperty
    a_disable_abort: assert property (p_disable_abort)
        else $error("disable left the converter busy");

    property p_busy_drops_edge;
        (trigEdge && s_reg.busy && !finished) |=> !conv.convStart;
    endproperty
    a_busy_drops_edge: assert property (p_busy_drops_edge)
        else $error("edge during a conversion started another");

    property p_done_clear;
        (wrA && apbReq.pwdata[BIT_DONE] && !finished) |=> !conv.doneFlag;
    endproperty
    a_done_clear: assert property (p_done_clear)
        else $error("write one did not clear the done flag");

    property p_done_hold;
        (conv.doneFlag && !(wrA && apbReq.pwdata[BIT_DONE]))
            |=> conv.doneFlag;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done flag dropped without a clear");

    property p_sel_hold;
        !wrB |=> $stable(s_reg.trigSel);
    endproperty
    a_sel_hold: assert property (p_sel_hold)
        else $error("source field changed without a write");

    property p_buf_hold;
        !wrD |=> $stable(inputBufferOff);
    endproperty
    a_buf_hold: assert property (p_buf_hold)
        else $error("buffer disables changed without a write");

    property p_pin_follow;
        !wrD |=> pinValue == ($past(pinSync) & ~inputBufferOff);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("pin value does not follow the synced pin");

    property p_resv_d;
        (rdSetup && selD) |=> apbRsp.prdata[7:6] == 2'h0;
    endproperty
    a_resv_d: assert property (p_resv_d)
        else $error("missing disable bits read non zero");

    c_edge_start: cover property (hwTrig ##1 conv.convStart);
    c_free_run: cover property (freeRun ##1 conv.convStart);
    c_switch: cover property (wrB ##1 trigEdge);
    c_masked: cover property (wrD && apbReq.pwdata[0] && pinSync[0]);
    c_sw_start: cover property (swStart ##1 conv.convStart);

endmodule : adt_ctrl

// ===== tb/adt_src_model.sv
`timescale 1ns/100ps
module adt_src_model
    import adt_pkg::*;
#(
    parameter int CONV_LAT = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // flag levels asked for by the bench, code 7 down to 1
    input wire logic [6:0] flagSet,
    // converter core handshake
    input wire logic convStart,
    output adt_trig_s trig,
    output logic convDone
);
    int cnt;

    // ------------------------------------------------------------------
    // event flags and converter core
    // ------------------------------------------------------------------
    // flags move just after an edge, as real event flags would
    always @(posedge clk) begin
        trig <= adt_trig_s'(flagSet);
    end

    // core ends each conversion a fixed time after its start pulse
    always @(posedge clk) begin
        convDone <= 1'b0;
        if (!resetn) begin
            cnt <= 0;
        end else if (convStart) begin
            cnt <= CONV_LAT;
        end else if (cnt == 1) begin
            cnt <= 0;
            convDone <= 1'b1;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : adt_src_model

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb
    import adt_pkg::*;
;
    logic clk = 1'b0;
    logic resetn;
    adt_apb_req_s apbReq;
    adt_apb_rsp_s apbRsp;
    adt_trig_s trig;
    adt_conv_s conv;
    logic convDone;
    logic [6:0] flagSet;
    logic [NUM_DIG_PINS-1:0] pinRaw;
    logic [NUM_DIG_PINS-1:0] inputBufferOff;
    logic [NUM_DIG_PINS-1:0] pinValue;
    int errCount = 0;
    int checkCount = 0;
    int starts = 0;
    int cycles = 0;

    adt_ctrl i_dut (.clk(clk), .resetn(resetn), .apbReq(apbReq),
        .apbRsp(apbRsp), .trig(trig), .convDone(convDone), .conv(conv),
        .pinRaw(pinRaw), .inputBufferOff(inputBufferOff),
        .pinValue(pinValue));

    adt_src_model #(.CONV_LAT(4)) i_src (.clk(clk), .resetn(resetn),
        .flagSet(flagSet), .convStart(conv.convStart), .trig(trig),
        .convDone(convDone));

    // ------------------------------------------------------------------
    // clock, start counter, hang guard
    // ------------------------------------------------------------------
    always #10 clk = ~clk;

    // start pulses stand one cycle, so each edge sees at most one
    always @(posedge clk) begin
        if (conv.convStart === 1'b1) starts++;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            $display("timeout after %0d cycles", cycles);
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check(input string nm, input logic [31:0] exp,
            input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    // one apb transfer; an idle edge follows so no signal is set twice
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
            input logic [7:0] wd, output logic [31:0] rd, output logic err);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
            pwdata: {24'h000000, wd}, pstrb: 4'hF};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        @(posedge clk);
        // no wait limit here; the cycle guard ends a hang
        while (apbRsp.pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = apbRsp.prdata;
        err = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a,
            input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        check(nm, {24'h000000, exp}, r);
        check(nm, 32'h0, {31'h0, e});
    endtask : rdchk

    // lower all flags, then raise f and count the starts that follow
    task automatic flag_edge(input string nm, input logic [6:0] f,
            input int expN);
        int s0;
        flagSet <= 7'h00;
        repeat (3) @(posedge clk);
        s0 = starts;
        flagSet <= f;
        repeat (20) @(posedge clk);
        check(nm, 32'(expN), 32'(starts - s0));
    endtask : flag_edge

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_regs();
        logic [31:0] r;
        logic e;
        rdchk("ctrl a reset", ADDR_CTRL_A, CTRL_A_RST);
        rdchk("ctrl b reset", ADDR_CTRL_B, CTRL_B_RST);
        rdchk("disable reset", ADDR_INPUT_OFF, INPUT_OFF_RST);
        wr(ADDR_CTRL_B, 8'h47);
        rdchk("ctrl b", ADDR_CTRL_B, 8'h47);
        check("mux enable", 32'h1, {31'h0, conv.compMuxEn});
        wr(ADDR_CTRL_A, 8'h0D);
        rdchk("ctrl a", ADDR_CTRL_A, 8'h0D);
        check("prescaler", 32'h5, {29'h0, conv.clkDiv});
        check("irq enable", 32'h1, {31'h0, conv.doneIrqEn});
        wr(ADDR_CTRL_A, 8'h00);
        apb(1'b0, 12'h000, 8'h00, r, e);
        check("unmapped err", 32'h1, {31'h0, e});
        check("unmapped data", 32'h0, r);
        wr(ADDR_CTRL_B, 8'h00);
        $display("test regs done");
    endtask : test_regs

    task automatic test_sources();
        int s0;
        wr(ADDR_CTRL_A, 8'hA0);
        check("enable", 32'h1, {31'h0, conv.convOn});
        for (int c = 1; c < 8; c++) begin
            wr(ADDR_CTRL_B, 8'(c));
            s0 = starts;
            flagSet <= 7'h7F & ~(7'h01 << (c - 1));
            repeat (10) @(posedge clk);
            check("other flags", 32'h0, 32'(starts - s0));
            flagSet <= 7'h7F;
            repeat (20) @(posedge clk);
            check("own flag", 32'h1, 32'(starts - s0));
            check("done", 32'h1, {31'h0, conv.doneFlag});
            wr(ADDR_CTRL_A, 8'hB0);
            check("done clear", 32'h0, {31'h0, conv.doneFlag});
            flagSet <= 7'h00;
        end
        $display("test sources done");
    endtask : test_sources

    task automatic test_switch();
        int s0;
        // the flag rises while the clear comparator source is selected
        wr(ADDR_CTRL_B, 8'h01);
        flagSet <= 7'h02;
        s0 = starts;
        wr(ADDR_CTRL_B, 8'h02);
        repeat (20) @(posedge clk);
        check("switch", 32'h1, 32'(starts - s0));
        wr(ADDR_CTRL_B, 8'h00);
        repeat (10) @(posedge clk);
        check("to free run", 32'h1, 32'(starts - s0));
        wr(ADDR_CTRL_B, 8'h02);
        wr(ADDR_CTRL_A, 8'h90);
        flag_edge("auto off", 7'h02, 0);
        wr(ADDR_CTRL_A, 8'h20);
        flag_edge("conv off", 7'h02, 0);
        flagSet <= 7'h00;
        $display("test switch done");
    endtask : test_switch

    task automatic test_free_run();
        int s0;
        wr(ADDR_CTRL_B, 8'h00);
        s0 = starts;
        wr(ADDR_CTRL_A, 8'hE0);
        repeat (40) @(posedge clk);
        check("restarts", 32'h1, {31'h0, (starts - s0) >= 4});
        wr(ADDR_CTRL_A, 8'h00);
        repeat (10) @(posedge clk);
        s0 = starts;
        repeat (20) @(posedge clk);
        check("stopped", 32'h0, 32'(starts - s0));
        $display("test free run done");
    endtask : test_free_run

    task automatic test_pins();
        pinRaw <= 6'h3F;
        repeat (5) @(posedge clk);
        check("pins open", 32'h3F, {26'h0, pinValue});
        wr(ADDR_INPUT_OFF, 8'h15);
        repeat (2) @(posedge clk);
        check("buffers", 32'h15, {26'h0, inputBufferOff});
        check("pins masked", 32'h2A, {26'h0, pinValue});
        wr(ADDR_INPUT_OFF, 8'h3F);
        rdchk("disable reg", ADDR_INPUT_OFF, 8'h3F);
        check("pins all off", 32'h0, {26'h0, pinValue});
        $display("test pins done");
    endtask : test_pins

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        apbReq = '0;
        flagSet = 7'h00;
        pinRaw = 6'h00;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        test_regs();
        test_sources();
        test_switch();
        test_free_run();
        test_pins();
        complete_run();
    end
endmodule : tb
